// File: verilog/sadc_pkg.sv
package sadc_pkg;
  // widths and edge numbers of a transfer
  localparam int RES_W = 10;
  localparam int ADDR_W = 4;
  localparam int CNT_W = 5;
  localparam int TMR_W = 11;
  localparam int ADDR_BITS = 4;
  localparam int SAMPLE_EDGE = 4;
  localparam int HOLD_EDGE = 10;
  localparam int FAST_LEN = 10;
  localparam int SLOW_MIN_LEN = 11;
  localparam int FULL_LEN = 16;
  localparam int FIFO_DEPTH = 4;
  // channel codes
  localparam logic [3:0] CH_EXT_LAST = 4'ha;
  localparam logic [3:0] CH_TEST_MID = 4'hb;
  localparam logic [3:0] CH_TEST_LO = 4'hc;
  localparam logic [3:0] CH_TEST_HI = 4'hd;
  localparam logic [1:0] TEST_NONE = 2'h0;
  localparam logic [1:0] TEST_MID = 2'h1;
  localparam logic [1:0] TEST_LO = 2'h2;
  localparam logic [1:0] TEST_HI = 2'h3;
  localparam logic [9:0] TEST_MID_CODE = 10'h200;
  localparam logic [9:0] TEST_LO_CODE = 10'h000;
  localparam logic [9:0] TEST_HI_CODE = 10'h3ff;
  localparam logic [9:0] MSB_WEIGHT = 10'h200;
  localparam logic [9:0] LSB_WEIGHT = 10'h001;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  // timing
  localparam int SYS_PERIOD_PS = 8000;
  localparam int CONV_TIME_NS = 5500;
  localparam int BIT_CYC = (CONV_TIME_NS * 1000) / (RES_W * SYS_PERIOD_PS);
  localparam int IO_HALF_NS = 480;
  localparam int IO_HALF_CYC = (IO_HALF_NS * 1000) / SYS_PERIOD_PS;
  localparam int CS_SETUP_NS = 1425;
  localparam int CS_SETUP_CYC =
    (CS_SETUP_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam int SLOW_GAP_NS = 9500;
  localparam int SLOW_GAP_CYC = (SLOW_GAP_NS * 1000) / SYS_PERIOD_PS;
  typedef enum logic [1:0] {
    DV_IDLE, DV_XFER, DV_CONV, DV_TAIL
  } sadc_dev_state_type;
  typedef enum logic [2:0] {
    HS_IDLE, HS_SETUP, HS_LOW, HS_HIGH, HS_WAIT
  } sadc_host_state_type;
endpackage : sadc_pkg

// File: verilog/sadc_link_if.sv
`timescale 1ns/1ps
interface sadc_link_if;
  logic cs_n;
  logic io_clk;
  logic addr;
  logic dout_o;
  logic dout_oe;
  logic eoc;
  wire dout_level;
  // released line reads high, as with a pull-up
  assign dout_level = dout_oe ? dout_o : 1'h1;
  modport dev (input cs_n, io_clk, addr, output dout_o, dout_oe, eoc);
  modport host (output cs_n, io_clk, addr, input dout_level, eoc);
endinterface : sadc_link_if

// File: verilog/sadc_fifo.sv
`timescale 1ns/1ps
module sadc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  // system
  input wire logic sys_clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;
  wire full = (wr_ptr[PW] != rd_ptr[PW]) &&
    (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
  wire empty = wr_ptr == rd_ptr;
  wire do_wr = in_valid && !full;
  wire do_rd = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[PW-1:0]];
  always_ff @(posedge sys_clk) begin
    if (do_wr) mem[wr_ptr[PW-1:0]] <= in_data;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : sadc_fifo

// File: verilog/sadc_dev.sv
// Behaviour
// - select falling drives output, shows previous MSB
// - select rising releases output, ignores clock, address
// - fast modes use exactly ten clocks
// - done rising restarts sequence when select held
// - select-pulsed long transfers use 11 to 16
// - held-select long transfers use exactly sixteen
// - slow mode eleventh rise within 9.5 us; the code needs it before the result lands, 680 cycles after the tenth fall
// - late eleventh rise loses sync until reselect
// - slow held mode restarts on sixteenth fall
// - address MSB first on first four rises
// - codes 0-a external, b-d self-test
// - self-test targets midpoint, low, high reference
// - sample from fourth fall, hold at tenth
// - above trip clears bit, else keeps it
// - ten decisions from weight 512 downward
// - select falling aborts, result register kept
// - host avoids select falling near completion
// - clamp to full scale or zero
// - done low at tenth fall, high when ready
// - nine further bits on next falling edges
// - output low from tenth fall onward
`timescale 1ns/1ps
module sadc_dev (
  // system
  input wire logic sys_clk,
  input wire logic rst,
  // serial link
  sadc_link_if.dev link,
  // analog front end
  output logic [sadc_pkg::ADDR_W-1:0] mux_sel,
  output logic ext_sel,
  output logic [1:0] test_sel,
  output logic sample_en,
  output logic [sadc_pkg::RES_W-1:0] trial_code,
  input wire logic cmp_above,
  input wire logic in_over_hi,
  input wire logic in_under_lo,
  // results
  output logic [sadc_pkg::RES_W-1:0] result,
  output logic conv_done
);
  import sadc_pkg::*;

  function automatic logic [1:0] test_of(input logic [3:0] code);
    case (code)
      CH_TEST_MID: test_of = TEST_MID;
      CH_TEST_LO: test_of = TEST_LO;
      CH_TEST_HI: test_of = TEST_HI;
      default: test_of = TEST_NONE;
    endcase
  endfunction : test_of

  function automatic logic [9:0] target_of(input logic [1:0] sel);
    case (sel)
      TEST_MID: target_of = TEST_MID_CODE;
      TEST_LO: target_of = TEST_LO_CODE;
      default: target_of = TEST_HI_CODE;
    endcase
  endfunction : target_of

  function automatic logic [4:0] sat_inc(input logic [4:0] v);
    sat_inc = (v >= 5'(FULL_LEN)) ? v : v + 5'h01;
  endfunction : sat_inc

  sadc_dev_state_type state;
  sadc_dev_state_type next_state;
  logic cs_s1, cs_s2, cs_s3;
  logic ck_s1, ck_s2, ck_s3;
  logic ad_s1, ad_s2;
  logic [CNT_W-1:0] rise_cnt;
  logic [CNT_W-1:0] fall_cnt;
  logic [ADDR_W-1:0] addr_sr;
  logic [RES_W-1:0] out_sr;
  logic [RES_W-1:0] mask;
  logic [TMR_W-1:0] tmr;
  logic oe;
  logic eoc;
  logic clamp_hi;
  logic clamp_lo;

  // pins come from the host's domain
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      {ck_s1, ck_s2, ck_s3} <= 3'h0;
      {ad_s1, ad_s2} <= 2'h0;
    end else begin
      {cs_s1, cs_s2, cs_s3} <= {link.cs_n, cs_s1, cs_s2};
      {ck_s1, ck_s2, ck_s3} <= {link.io_clk, ck_s1, ck_s2};
      {ad_s1, ad_s2} <= {link.addr, ad_s1};
    end
  end

  wire cs_low = !cs_s2;
  wire cs_fall = !cs_s2 && cs_s3;
  wire cs_rise = cs_s2 && !cs_s3;
  // select judged one cycle late: a last fall that meets the select
  // rise still counts, since the host may move both together
  wire ck_rise = !cs_s3 && ck_s2 && !ck_s3;
  wire ck_fall = !cs_s3 && !ck_s2 && ck_s3;
  wire in_xfer = state == DV_XFER;
  wire samp_evt = in_xfer && ck_fall && fall_cnt == 5'(SAMPLE_EDGE - 1);
  wire hold_evt = in_xfer && ck_fall && fall_cnt == 5'(HOLD_EDGE - 1);
  wire bit_tick = state == DV_CONV && tmr == '0 && !cs_fall;
  wire last_bit = bit_tick && mask == LSB_WEIGHT;
  // self-test inputs compare against their ideal code
  wire above = (test_sel != TEST_NONE) ?
    (trial_code > target_of(test_sel)) : cmp_above;
  wire [RES_W-1:0] decided =
    above ? (trial_code & ~mask) : trial_code;
  wire [RES_W-1:0] final_code = clamp_hi ? TEST_HI_CODE :
    (clamp_lo ? TEST_LO_CODE : decided);
  // transfer still running when the result lands: wait for the 16th fall
  wire to_tail = last_bit && cs_low && rise_cnt >= 5'(SLOW_MIN_LEN) &&
    fall_cnt < 5'(FULL_LEN);
  // a late 11th rise is then taken as the first of a new transfer
  wire held_restart = last_bit && cs_low && !to_tail;
  wire tail_restart = state == DV_TAIL && ck_fall && cs_low &&
    fall_cnt == 5'(FULL_LEN - 1);
  wire start_seq = cs_fall || held_restart || tail_restart;
  wire [RES_W-1:0] seq_word = held_restart ? final_code : result;

  always_comb begin
    next_state = state;
    if (cs_fall) begin
      next_state = DV_XFER;
    end else begin
      case (state)
        DV_IDLE: next_state = DV_IDLE;
        DV_XFER: begin
          if (hold_evt) next_state = DV_CONV;
          else if (cs_rise) next_state = DV_IDLE;
        end
        // conversion goes on with select high
        DV_CONV: begin
          if (last_bit && !cs_low) next_state = DV_IDLE;
          else if (to_tail) next_state = DV_TAIL;
          else if (held_restart) next_state = DV_XFER;
        end
        DV_TAIL: begin
          if (tail_restart) next_state = DV_XFER;
          else if (cs_rise) next_state = DV_IDLE;
        end
        default: next_state = DV_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) state <= DV_IDLE;
    else state <= next_state;
  end

  always_ff @(posedge sys_clk) begin
    if (rst || start_seq) begin
      rise_cnt <= '0;
      fall_cnt <= '0;
      addr_sr <= '0;
    end else begin
      if (ck_rise) rise_cnt <= sat_inc(rise_cnt);
      if (ck_fall) fall_cnt <= sat_inc(fall_cnt);
      if (ck_rise && rise_cnt < 5'(ADDR_BITS))
        addr_sr <= {addr_sr[ADDR_W-2:0], ad_s2};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) out_sr <= '0;
    else if (start_seq) out_sr <= seq_word;
    else if (ck_fall && fall_cnt >= 5'(HOLD_EDGE - 1)) out_sr <= '0;
    else if (ck_fall) out_sr <= {out_sr[RES_W-2:0], 1'h0};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) oe <= 1'h0;
    else if (cs_fall) oe <= 1'h1;
    else if (cs_rise) oe <= 1'h0;
  end

  always_ff @(posedge sys_clk) begin
    if (rst || cs_fall) eoc <= 1'h1;
    else if (hold_evt) eoc <= 1'h0;
    else if (last_bit) eoc <= 1'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sample_en <= 1'h0;
      mux_sel <= '0;
      ext_sel <= 1'h0;
      test_sel <= TEST_NONE;
      clamp_hi <= 1'h0;
      clamp_lo <= 1'h0;
    end else if (cs_fall) begin
      sample_en <= 1'h0;
    end else if (samp_evt) begin
      sample_en <= 1'h1;
      mux_sel <= addr_sr;
      ext_sel <= addr_sr <= CH_EXT_LAST;
      test_sel <= test_of(addr_sr);
    end else if (hold_evt) begin
      sample_en <= 1'h0;
      clamp_hi <= in_over_hi;
      clamp_lo <= in_under_lo;
    end
  end

  // one decision every BIT_CYC cycles
  always_ff @(posedge sys_clk) begin
    if (rst || cs_fall) begin
      mask <= '0;
      trial_code <= '0;
      tmr <= '0;
    end else if (hold_evt) begin
      mask <= MSB_WEIGHT;
      trial_code <= MSB_WEIGHT;
      tmr <= TMR_W'(BIT_CYC - 1);
    end else if (state == DV_CONV && tmr != '0) begin
      tmr <= tmr - 1'b1;
    end else if (bit_tick) begin
      mask <= mask >> 1;
      trial_code <= decided | (mask >> 1);
      tmr <= TMR_W'(BIT_CYC - 1);
    end
  end

  // an abort in the finishing cycle leaves the old result
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result <= RESULT_RESET;
      conv_done <= 1'h0;
    end else begin
      conv_done <= last_bit;
      if (last_bit) result <= final_code;
    end
  end

  assign link.dout_o = out_sr[RES_W-1];
  assign link.dout_oe = oe;
  assign link.eoc = eoc;
endmodule : sadc_dev

// File: verilog/sadc_host.sv
`timescale 1ns/1ps
module sadc_host (
  // system
  input wire logic sys_clk,
  input wire logic rst,
  // serial link
  sadc_link_if.host link,
  // transfer request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [sadc_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [sadc_pkg::CNT_W-1:0] cmd_len,
  input wire logic cmd_hold,
  // received words
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [sadc_pkg::RES_W-1:0] rd_data
);
  import sadc_pkg::*;

  // held select allows 10 or 16, pulsed select 10 to 16
  function automatic logic [4:0] legal_len(input logic [4:0] len,
                                           input logic hold);
    if (hold) legal_len = (len > 5'(FAST_LEN)) ? 5'(FULL_LEN) : 5'(FAST_LEN);
    else if (len < 5'(FAST_LEN)) legal_len = 5'(FAST_LEN);
    else if (len > 5'(FULL_LEN)) legal_len = 5'(FULL_LEN);
    else legal_len = len;
  endfunction : legal_len

  sadc_host_state_type state;
  logic e_s1, e_s2, d_s1, d_s2;
  logic cs_n;
  logic io_clk;
  logic addr_q;
  logic [ADDR_W-1:0] addr_buf;
  logic [CNT_W-1:0] len;
  logic [CNT_W-1:0] cnt;
  logic hold;
  logic [TMR_W-1:0] tmr;
  logic [RES_W-1:0] rx_sr;
  logic push;
  logic eoc_low_seen;
  logic fifo_in_ready;

  always_ff @(posedge sys_clk) begin
    if (rst) {e_s1, e_s2, d_s1, d_s2} <= 4'hf;
    else {e_s1, e_s2, d_s1, d_s2} <= {link.eoc, e_s1, link.dout_level, d_s1};
  end

  wire tmr_done = tmr == '0;
  wire [CNT_W-1:0] cnt_inc = cnt + 5'h01;
  assign cmd_ready = state == HS_IDLE && fifo_in_ready;

  always_ff @(posedge sys_clk) begin
    if (rst || state == HS_IDLE) eoc_low_seen <= 1'h0;
    else if (!e_s2) eoc_low_seen <= 1'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= HS_IDLE;
      cs_n <= 1'h1;
      io_clk <= 1'h0;
      addr_q <= 1'h0;
      addr_buf <= '0;
      len <= '0;
      cnt <= '0;
      hold <= 1'h0;
      tmr <= '0;
      rx_sr <= '0;
      push <= 1'h0;
    end else begin
      push <= 1'h0;
      if (!tmr_done) tmr <= tmr - 1'b1;
      case (state)
        HS_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            len <= legal_len(cmd_len, cmd_hold);
            hold <= cmd_hold;
            addr_buf <= cmd_addr;
            addr_q <= cmd_addr[ADDR_W-1];
            cnt <= '0;
            cs_n <= 1'h0;
            tmr <= TMR_W'(CS_SETUP_CYC - 1);
            state <= HS_SETUP;
          end
        end
        HS_SETUP: begin
          if (tmr_done) begin
            tmr <= TMR_W'(IO_HALF_CYC - 1);
            state <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (tmr_done) begin
            io_clk <= 1'h1;
            if (cnt < 5'(FAST_LEN)) rx_sr <= {rx_sr[RES_W-2:0], d_s2};
            tmr <= TMR_W'(IO_HALF_CYC - 1);
            state <= HS_HIGH;
          end
        end
        // fixed rate keeps the 11th rise far inside SLOW_GAP_CYC
        HS_HIGH: begin
          if (tmr_done) begin
            io_clk <= 1'h0;
            cnt <= cnt_inc;
            addr_buf <= {addr_buf[ADDR_W-2:0], 1'h0};
            addr_q <= addr_buf[ADDR_W-2];
            tmr <= TMR_W'(IO_HALF_CYC - 1);
            if (cnt_inc == len) begin
              if (!hold) cs_n <= 1'h1;
              push <= 1'h1;
              state <= HS_WAIT;
            end else begin
              state <= HS_LOW;
            end
          end
        end
        // select only moves again once the result is ready
        HS_WAIT: begin
          if (eoc_low_seen && e_s2) state <= HS_IDLE;
        end
        default: state <= HS_IDLE;
      endcase
    end
  end

  sadc_fifo #(.WIDTH(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(rx_sr),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  assign link.cs_n = cs_n;
  assign link.io_clk = io_clk;
  assign link.addr = addr_q;
endmodule : sadc_host

// File: dv/sadc_link_chk.sv
`timescale 1ns/1ps
module sadc_link_chk (
  // system
  input wire logic sys_clk,
  input wire logic rst,
  // link
  input wire logic cs_n,
  input wire logic io_clk,
  input wire logic addr,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic eoc,
  input wire logic dout_level
);
  wire logic fall_w;
  wire logic start_w;
  wire logic eoc_fall_w;
  wire logic eoc_rise_w;
  logic io_q;
  logic cs_q;
  logic eoc_q;
  logic eoc_seen;
  logic [4:0] n_fall;
  logic [3:0] since_fall;
  logic [3:0] since_eoc;
  logic [9:0] lo_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  assign fall_w = io_q & ~io_clk;
  assign start_w = cs_q & ~cs_n;
  assign eoc_fall_w = eoc_q & ~eoc;
  assign eoc_rise_w = eoc & ~eoc_q;
  always_ff @(posedge sys_clk) begin
    io_q <= io_clk;
    cs_q <= cs_n;
    eoc_q <= eoc;
  end
  // held frames pile up falls, so only the first conversion is judged
  always_ff @(posedge sys_clk) begin
    if (rst || start_w) begin
      n_fall <= 5'h00;
      eoc_seen <= 1'h0;
    end else begin
      if (fall_w && n_fall != 5'h1f)
        n_fall <= n_fall + 5'h01;
      if (eoc_fall_w)
        eoc_seen <= 1'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst || fall_w)
      since_fall <= 4'h0;
    else if (since_fall != 4'hf)
      since_fall <= since_fall + 4'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst || eoc_rise_w)
      since_eoc <= 4'h0;
    else if (since_eoc != 4'hf)
      since_eoc <= since_eoc + 4'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst || eoc)
      lo_cnt <= 10'h000;
    else if (lo_cnt != 10'h3ff)
      lo_cnt <= lo_cnt + 10'h001;
  end
  AST_OE_ON: assert property ($fell(cs_n) |-> ##[1:6] dout_oe)
    else $error("data output not driven after select fall");
  AST_OE_OFF: assert property ($rose(cs_n) |-> ##[1:6] !dout_oe)
    else $error("data output not released after select rise");
  AST_HIZ: assert property (cs_n [*8] |-> !dout_oe && dout_level)
    else $error("data output driven while deselected");
  AST_CLK_FRAME: assert property ($rose(io_clk) |-> !cs_n)
    else $error("shift clock toggles outside a frame");
  // last fall and select rise may share an edge: judge the count after
  AST_MIN_TEN: assert property ($rose(cs_n) |=> n_fall >= 5'h0a)
    else $error("frame closed with fewer than ten clocks");
  AST_ADDR_LOW: assert property ($changed(addr) |-> !io_clk)
    else $error("address bit changed while shift clock high");
  AST_EOC_TENTH: assert property (
    eoc_fall_w && !eoc_seen |-> n_fall == 5'h0a)
    else $error("done fell away from the tenth falling edge");
  AST_CONV_LEN: assert property (
    eoc_rise_w |-> lo_cnt inside {[10'h29e:10'h2bc]})
    else $error("conversion time off");
  AST_DATA_ZERO: assert property (
    !eoc [*3] ##0 dout_oe |-> !dout_o)
    else $error("data output not low during conversion");
  AST_SHIFT_EDGE: assert property (
    dout_oe && $past(dout_oe) && $past(dout_oe, 2) && $changed(dout_o)
    |-> since_fall < 4'h8 || since_eoc < 4'h8 || eoc_rise_w)
    else $error("data bit changed away from a shift edge");
endmodule : sadc_link_chk

// File: dv/serial_adc_sequencer_test.sv
`timescale 1ns/1ps
module serial_adc_sequencer_test;
  import sadc_pkg::*;
  localparam int LIM = 20000;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic cmd_valid = 1'h0;
  logic cmd_ready;
  logic [ADDR_W-1:0] cmd_addr = 4'h0;
  logic [CNT_W-1:0] cmd_len = 5'h0a;
  logic cmd_hold = 1'h0;
  logic rd_valid;
  logic rd_ready = 1'h0;
  logic [RES_W-1:0] rd_data;
  logic [ADDR_W-1:0] mux_sel;
  logic ext_sel;
  logic [1:0] test_sel;
  logic sample_en;
  logic [RES_W-1:0] trial_code;
  logic [RES_W-1:0] result;
  logic conv_done;
  logic in_over_hi = 1'h0;
  logic in_under_lo = 1'h0;
  logic [RES_W-1:0] vin = 10'h000;
  logic stall = 1'h1;
  logic [2:0] tick = 3'h0;
  wire logic cmp_above;
  int seed = 49224;
  int n_errors = 0;
  int compares = 0;
  int samp_len = 0;
  logic [RES_W-1:0] exp_rd[$];
  logic [16:0] exp_conv[$];
  sadc_link_if link();
  // ideal comparator: trial above the held input clears the bit
  assign cmp_above = trial_code > vin;
  always #4 sys_clk = ~sys_clk;
  sadc_dev i_sadc_dev (.sys_clk(sys_clk), .rst(rst), .link(link.dev),
    .mux_sel(mux_sel), .ext_sel(ext_sel), .test_sel(test_sel),
    .sample_en(sample_en), .trial_code(trial_code),
    .cmp_above(cmp_above), .in_over_hi(in_over_hi),
    .in_under_lo(in_under_lo), .result(result), .conv_done(conv_done));
  sadc_host i_sadc_host (.sys_clk(sys_clk), .rst(rst), .link(link.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .cmd_hold(cmd_hold), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data));
  sadc_link_chk i_sadc_link_chk (.sys_clk(sys_clk), .rst(rst),
    .cs_n(link.cs_n), .io_clk(link.io_clk), .addr(link.addr),
    .dout_o(link.dout_o), .dout_oe(link.dout_oe), .eoc(link.eoc),
    .dout_level(link.dout_level));
  task automatic cmp(input string name, input logic [16:0] e,
                     input logic [16:0] got);
    compares++;
    if (got !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, e, got);
    end
  endtask : cmp
  task automatic chk_word(input logic [RES_W-1:0] got);
    logic [RES_W-1:0] e;
    e = exp_rd.size() ? exp_rd.pop_front() : ~got;
    cmp("rd_data", {7'h00, e}, {7'h00, got});
  endtask : chk_word
  task automatic chk_conv(input logic [16:0] got);
    logic [16:0] e;
    e = exp_conv.size() ? exp_conv.pop_front() : ~got;
    cmp("conversion", e, got);
  endtask : chk_conv
  // window runs from the fourth to the tenth fall: six link periods
  task automatic chk_samp(input int got);
    cmp("sample_en", 17'((HOLD_EDGE - SAMPLE_EDGE) * 2 * IO_HALF_CYC),
      17'(got));
  endtask : chk_samp
  task automatic results();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  task automatic wait_ready();
    int t;
    t = 0;
    while (cmd_ready !== 1'h1 && t < LIM) begin
      @(posedge sys_clk);
      #1;
      t++;
    end
    if (t == LIM) begin
      n_errors++;
      results();
    end
  endtask : wait_ready
  // drain side stalls part of the time so the fifo backs up
  always begin
    @(posedge sys_clk);
    #1;
    tick = tick + 3'h1;
    rd_ready = !stall && tick[1:0] != 2'h0;
  end
  always @(posedge sys_clk) begin
    if (!rst && conv_done)
      chk_conv({mux_sel, ext_sel, test_sel, result});
    if (!rst && rd_valid && rd_ready)
      chk_word(rd_data);
    if (!rst && sample_en) begin
      samp_len++;
    end else if (samp_len != 0) begin
      chk_samp(samp_len);
      samp_len = 0;
    end
  end
  initial begin : main
    int c;
    int t;
    logic [RES_W-1:0] v;
    logic [RES_W-1:0] prev;
    logic [1:0] ts;
    prev = RESULT_RESET;
    repeat (20) @(posedge sys_clk);
    #1;
    rst = 1'h0;
    for (int i = 0; i < 14; i++) begin
      if (i == 4) begin
        // four words unread: host must refuse a fifth
        repeat (3500) @(posedge sys_clk);
        #1;
        cmp("cmd_ready", 17'h0, {16'h0, cmd_ready});
        stall = 1'h0;
      end
      wait_ready();
      c = (i * 5) % 14;
      vin = 10'($random(seed));
      in_over_hi = (i == 2 || i == 3);
      in_under_lo = (i == 3 || i == 6);
      cmd_addr = 4'(c);
      cmd_len = (i % 4 == 3) ? 5'(10 + (i % 7)) : (i % 4 == 1) ? 5'h10
              : (i % 4 == 2) ? 5'h0b : 5'h0a;
      cmd_hold = (i % 3 == 1) && i != 13;
      v = (c == 11) ? TEST_MID_CODE : (c == 12) ? TEST_LO_CODE
        : (c == 13) ? TEST_HI_CODE : in_over_hi ? 10'h3ff
        : in_under_lo ? 10'h000 : vin;
      ts = (c > 10) ? 2'(c - 10) : TEST_NONE;
      exp_conv.push_back({4'(c), c <= 10, ts, v});
      exp_rd.push_back(prev);
      prev = v;
      cmd_valid = 1'h1;
      @(posedge sys_clk);
      #1;
      cmd_valid = 1'h0;
    end
    wait_ready();
    t = 0;
    while ((exp_rd.size() || exp_conv.size()) && t < LIM) begin
      @(posedge sys_clk);
      #1;
      t++;
    end
    if (t == LIM)
      n_errors++;
    results();
  end
endmodule : serial_adc_sequencer_test
